/* File: hdl/spd_pkg.sv */
/*
  spd_pkg: shared constants and types for the user-side controller that
  sits on the split target/engine ports of the host-side adapter.
  Assumes: nothing beyond a SystemVerilog compiler.
*/
package spd_pkg;
  // software register byte offsets (32-bit words, avalon byte addressing)
  localparam logic [5:0] REG_CTRL      = 6'h00; // rw: accept and go enables
  localparam logic [5:0] REG_STATUS    = 6'h04; // ro: busy flags, last window
  localparam logic [5:0] REG_WR_COUNT  = 6'h08; // ro: target write beats taken
  localparam logic [5:0] REG_RD_COUNT  = 6'h0C; // ro: target reads taken
  localparam logic [5:0] REG_IN_DWORDS = 6'h10; // ro: inbound data dwords seen
  localparam logic [5:0] REG_IN_SUM    = 6'h14; // ro: sum of inbound dwords
  localparam logic [5:0] REG_DEM_ADDR  = 6'h18; // rw: demand board address
  localparam logic [5:0] REG_DEM_CMD   = 6'h1C; // wo: demand length, direction
  localparam logic [5:0] REG_LAST_LEN  = 6'h20; // ro: last length beat seen

  // control register fields
  localparam logic [2:0] CTRL_RESET    = 3'h7;  // all enables on
  localparam int         CTRL_WR_ACC   = 0;
  localparam int         CTRL_RD_ACC   = 1;
  localparam int         CTRL_GO       = 2;
  localparam int         CMD_DIR_BIT   = 31;    // 1: from-host demand request
  localparam int         LEN_W         = 24;    // dword count width

  // inbound flag fields
  localparam int         IN_TYPE_HI    = 5;
  localparam int         IN_TYPE_LO    = 0;
  localparam int         IN_READ       = 4;
  localparam logic [1:0] TYPE_ADDR     = 2'h1;
  localparam logic [1:0] TYPE_LEN      = 2'h2;
  localparam logic [1:0] TYPE_DATA     = 2'h0;

  // outbound flag fields
  localparam int         OUT_DEMAND    = 2;
  localparam int         OUT_EOF       = 3;
  localparam int         OUT_DESC      = 4;
  localparam int         OUT_RSV_HI    = 7;

  // outbound sender states, gray along idle-desc0-desc1-data
  typedef enum logic [1:0] {
    SND_IDLE  = 2'h0,
    SND_DESC0 = 2'h1,
    SND_DESC1 = 2'h3,
    SND_DATA  = 2'h2
  } spd_snd_e;

  // one outbound job: address, dword count, direction and mode
  typedef struct packed {
    logic [63:0]      addr;
    logic [LEN_W-1:0] len;
    logic             to_dev;
    logic             demand;
  } spd_job_s;
endpackage : spd_pkg

/* File: hdl/spd_mem.sv */
/*
  spd_mem: small byte-maskable register store behind the target port.
  Assumes: one clock, write and read index already decoded by the caller;
  read data appears one edge after the index.
*/
`timescale 1ns/1ns
`default_nettype none
module spd_mem #(
  parameter int W     = 64,
  parameter int DEPTH = 16
) (
  input  wire logic                     clock_in,
  input  wire logic                     wr_en_in,
  input  wire logic [$clog2(DEPTH)-1:0] wr_idx_in,
  input  wire logic [W-1:0]             wr_data_in,
  input  wire logic [W/8-1:0]           wr_mask_in,
  input  wire logic [$clog2(DEPTH)-1:0] rd_idx_in,
  output var  logic [W-1:0]             rd_data_out
);
  logic [W-1:0] store [DEPTH]; // no reset: contents are software's business

  // byte lanes written only where the mask allows; read data registered
  always_ff @(posedge clock_in) begin
    for (int b = 0; b < W/8; b++) begin
      if (wr_en_in && wr_mask_in[b]) begin
        store[wr_idx_in][8*b +: 8] <= wr_data_in[8*b +: 8];
      end
    end
    rd_data_out <= store[rd_idx_in];
  end
endmodule : spd_mem
`default_nettype wire

/* File: hdl/spd_user_end.sv */
/*
  spd_user_end: user logic on the far side of the split-port adapter.
  Serves target writes and reads from a small store, consumes engine 0
  inbound beats, answers host-memory reads and sends demand transfers
  on engine 0 outbound. Software steers it over avalon-mm.
  Assumes: adapter ports and avalon share clock_in; inputs synchronous.
*/
`timescale 1ns/1ns
`default_nettype none
module spd_user_end #(
  parameter int DATA_W    = 64,  // user data width: 64, 128 or 256
  parameter int MEM_DEPTH = 16,  // target store depth in data words
  // flag width tracks data width on the adapter side; the ports need it
  localparam int TAG_W    = (DATA_W == 64) ? 8 : (DATA_W == 128) ? 10 : 14
) (
  input  wire logic                 clock_in,
  input  wire logic                 rst_in,
  // software side, avalon-mm slave
  input  wire logic [5:0]           avs_address_in,
  input  wire logic                 avs_read_in,
  input  wire logic                 avs_write_in,
  input  wire logic [31:0]          avs_writedata_in,
  output logic      [31:0]          avs_readdata_out,
  output logic                      avs_waitrequest_out,
  // target port
  input  wire logic [63:0]          target_address_in,
  input  wire logic                 target_address_valid_in,
  input  wire logic [DATA_W-1:0]    target_write_data_in,
  input  wire logic [DATA_W/8-1:0]  register_wr_byte_mask_in,
  input  wire logic                 target_write_enable_in,
  output logic                      target_write_accept_out,
  input  wire logic [2:0]           debug_window_in,
  input  wire logic                 target_read_enable_in,
  input  wire logic [3:0]           target_request_tag_in,
  input  wire logic [DATA_W/8-1:0]  register_rd_byte_mask_in,
  input  wire logic [7:0]           target_read_ctrl_in,
  output logic                      target_read_accept_out,
  output logic      [DATA_W-1:0]    target_read_data_out,
  output logic      [3:0]           target_read_data_tag_out,
  output logic      [7:0]           target_read_data_ctrl_out,
  output logic                      target_read_data_valid_out,
  // engine 0 inbound
  input  wire logic [DATA_W-1:0]    engine0_inbound_word_in,
  input  wire logic [TAG_W-1:0]     engine0_inbound_flags_in,
  input  wire logic                 engine0_inbound_qualifier_in,
  output logic                      engine0_inbound_go_out,
  // engine 0 outbound
  output logic      [DATA_W-1:0]    engine0_outbound_word_out,
  output logic      [TAG_W:0]       engine0_outbound_flags_out,
  output logic                      engine0_outbound_qualifier_out,
  input  wire logic                 engine0_outbound_nearly_full_in
);
  localparam int DPB    = DATA_W / 32;          // dwords per beat
  localparam int LW     = $clog2(DPB);          // dword lane index width
  localparam int BOFS   = $clog2(DATA_W / 8);   // byte offset bits of address
  localparam int MAW    = $clog2(MEM_DEPTH);    // store index width

  // to-host dword valid bit for lane i: 0, 1, then 8 upward
  function automatic int out_bit(input int i);
    return (i < 2) ? i : i + 6;
  endfunction : out_bit

  // from-host dword valid bit for lane i: 2, 3, then 8 upward
  function automatic int in_bit(input int i);
    return (i < 2) ? i + 2 : i + 6;
  endfunction : in_bit

  // the whole state of this block
  typedef struct packed {
    logic [2:0]            ctrl;       // software enables
    logic                  avs_wait;   // registered waitrequest
    logic [31:0]           avs_rdata;  // registered read data
    logic [31:0]           wr_count;   // target write beats taken
    logic [31:0]           rd_count;   // target reads taken
    logic [31:0]           in_dwords;  // inbound data dwords
    logic [31:0]           in_sum;     // running sum of inbound dwords
    logic [31:0]           dem_addr;   // demand board address
    logic [24:0]           last_len;   // read flag and count of last length beat
    logic [2:0]            window;     // last window indicator seen
    logic [MAW-1:0]        tgt_idx;    // write index, steps per beat
    logic                  rd_phase;   // store read in flight
    logic [3:0]            rd_tag;     // tag captured with the request
    logic [7:0]            rd_ctrl;    // size captured with the request
    logic [DATA_W/8-1:0]   rd_mask;    // byte mask captured with request
    logic                  wr_acc;     // target write accept
    logic                  rd_acc;     // target read accept
    logic                  rd_valid;   // read data pulse
    logic [3:0]            rd_tag_out;
    logic [7:0]            rd_ctrl_out;
    logic [DATA_W-1:0]     rd_data;
    logic                  go;         // inbound go
    spd_pkg::spd_snd_e     snd;        // outbound sender state
    spd_pkg::spd_job_s     job;        // current outbound job
    logic [63:0]           in_addr;    // last inbound address beat
    logic [23:0]           remaining;  // dwords still to send
    logic [LW-1:0]         lane;       // first lane of next beat
    logic [31:0]           pattern;    // next outbound dword value
    logic [DATA_W-1:0]     out_word;
    logic [TAG_W:0]        out_flags;
    logic                  out_qual;
  } spd_state_s;

  spd_state_s   st;          // registered state
  spd_state_s   next_st;     // next state
  logic [DATA_W-1:0] mem_rdata;  // store read data, one edge after index
  logic              mem_we;     // store write strobe
  logic [MAW-1:0]    mem_widx;   // store write index
  logic              rd_take;    // target read request transfers now

  // write beats move only on enable with accept; index from strobe or step
  assign mem_we   = target_write_enable_in && st.wr_acc;
  assign mem_widx = target_address_valid_in ? target_address_in[BOFS +: MAW] : st.tgt_idx;
  assign rd_take  = target_read_enable_in && st.rd_acc;

  spd_mem #(.W(DATA_W), .DEPTH(MEM_DEPTH)) u_store (
    .clock_in    (clock_in),
    .wr_en_in    (mem_we),
    .wr_idx_in   (mem_widx),
    .wr_data_in  (target_write_data_in),
    .wr_mask_in  (register_wr_byte_mask_in),
    .rd_idx_in   (target_address_in[BOFS +: MAW]),
    .rd_data_out (mem_rdata)
  );

  // all next-state logic
  always_comb begin
    logic             avs_wr;
    logic             cmd_hit;
    logic [31:0]      acc;
    logic [31:0]      sum;
    logic [23:0]      cnt;
    avs_wr  = avs_write_in && !st.avs_wait;
    cmd_hit = 1'b0;
    acc     = '0;
    sum     = '0;
    cnt     = '0;
    next_st = st;

    // avalon: answer one cycle after the request appears, then release
    next_st.avs_wait  = !((avs_read_in || avs_write_in) && st.avs_wait);
    next_st.avs_rdata = '0;
    if (avs_read_in && st.avs_wait) begin
      unique case (avs_address_in)
        spd_pkg::REG_CTRL:      next_st.avs_rdata = {29'h0, st.ctrl};
        spd_pkg::REG_STATUS:    next_st.avs_rdata = {27'h0, st.window, st.rd_phase,
                                                     st.snd != spd_pkg::SND_IDLE};
        spd_pkg::REG_WR_COUNT:  next_st.avs_rdata = st.wr_count;
        spd_pkg::REG_RD_COUNT:  next_st.avs_rdata = st.rd_count;
        spd_pkg::REG_IN_DWORDS: next_st.avs_rdata = st.in_dwords;
        spd_pkg::REG_IN_SUM:    next_st.avs_rdata = st.in_sum;
        spd_pkg::REG_DEM_ADDR:  next_st.avs_rdata = st.dem_addr;
        spd_pkg::REG_LAST_LEN:  next_st.avs_rdata = {7'h0, st.last_len};
        default:                next_st.avs_rdata = '0; // unmapped reads zero
      endcase
    end
    if (avs_wr) begin
      // writes take effect at the edge where waitrequest is low
      if (avs_address_in == spd_pkg::REG_CTRL) begin
        next_st.ctrl = avs_writedata_in[2:0];
      end else if (avs_address_in == spd_pkg::REG_DEM_ADDR) begin
        next_st.dem_addr = avs_writedata_in;
      end else if (avs_address_in == spd_pkg::REG_DEM_CMD) begin
        cmd_hit = 1'b1;
      end
    end

    // target writes: count beats, step the index for bursts
    if (mem_we) begin
      next_st.wr_count = st.wr_count + 32'h1;
      next_st.tgt_idx  = mem_widx + MAW'(1);
    end else if (target_address_valid_in) begin
      next_st.tgt_idx  = target_address_in[BOFS +: MAW];
    end
    if (target_address_valid_in) begin
      next_st.window = debug_window_in; // kept for status only
    end

    // target reads: capture tag, size and mask; one request at a time
    next_st.rd_phase = rd_take;
    if (rd_take) begin
      next_st.rd_tag   = target_request_tag_in;
      next_st.rd_ctrl  = target_read_ctrl_in;
      next_st.rd_mask  = register_rd_byte_mask_in;
      next_st.rd_count = st.rd_count + 32'h1;
    end
    next_st.rd_valid = st.rd_phase;
    if (st.rd_phase) begin
      for (int b = 0; b < DATA_W/8; b++) begin
        next_st.rd_data[8*b +: 8] = st.rd_mask[b] ? mem_rdata[8*b +: 8] : 8'h00;
      end
      next_st.rd_tag_out  = st.rd_tag;
      next_st.rd_ctrl_out = st.rd_ctrl;
    end
    next_st.wr_acc = st.ctrl[spd_pkg::CTRL_WR_ACC];
    next_st.rd_acc = st.ctrl[spd_pkg::CTRL_RD_ACC] && !rd_take && !st.rd_phase;

    // inbound beats: type by flag bits five and zero
    if (engine0_inbound_qualifier_in) begin
      unique case ({engine0_inbound_flags_in[spd_pkg::IN_TYPE_HI],
                    engine0_inbound_flags_in[spd_pkg::IN_TYPE_LO]})
        spd_pkg::TYPE_ADDR: next_st.in_addr = engine0_inbound_word_in[63:0];
        spd_pkg::TYPE_LEN: begin
          next_st.last_len = {engine0_inbound_flags_in[spd_pkg::IN_READ],
                              engine0_inbound_word_in[23:0]};
          // a read asks for exactly this many dwords, aligned to the address
          if (engine0_inbound_flags_in[spd_pkg::IN_READ] &&
              st.snd == spd_pkg::SND_IDLE && engine0_inbound_word_in[23:0] != 24'h0) begin
            next_st.job       = '{addr: st.in_addr, len: engine0_inbound_word_in[23:0],
                                  to_dev: 1'b0, demand: 1'b0};
            next_st.remaining = engine0_inbound_word_in[23:0];
            next_st.lane      = st.in_addr[2 +: LW];
            next_st.snd       = spd_pkg::SND_DATA;
          end
        end
        spd_pkg::TYPE_DATA: begin
          acc = st.in_sum;
          for (int i = 0; i < DPB; i++) begin
            if (engine0_inbound_flags_in[in_bit(i)]) begin
              acc = acc + engine0_inbound_word_in[32*i +: 32];
              sum = sum + 32'h1;
            end
          end
          next_st.in_sum    = acc;
          next_st.in_dwords = st.in_dwords + sum;
        end
        default: ; // never sent by the adapter
      endcase
    end

    // demand command from software; an inbound read in the same cycle wins
    if (cmd_hit && st.snd == spd_pkg::SND_IDLE && next_st.snd == spd_pkg::SND_IDLE &&
        avs_writedata_in[23:0] != 24'h0) begin
      next_st.job       = '{addr: {32'h0, st.dem_addr}, len: avs_writedata_in[23:0],
                            to_dev: avs_writedata_in[spd_pkg::CMD_DIR_BIT], demand: 1'b1};
      next_st.remaining = avs_writedata_in[23:0];
      next_st.lane      = st.dem_addr[2 +: LW];
      next_st.snd       = spd_pkg::SND_DESC0;
    end

    // outbound sender: nothing moves while the adapter is nearly full
    next_st.out_qual  = 1'b0;
    next_st.out_flags = '0;
    if (!engine0_outbound_nearly_full_in) begin
      unique case (st.snd)
        spd_pkg::SND_IDLE: ;
        spd_pkg::SND_DESC0: begin
          next_st.out_word = '0;
          next_st.out_word[63:0] = st.job.addr;
          next_st.out_flags[spd_pkg::OUT_DESC]   = 1'b1;
          next_st.out_flags[spd_pkg::OUT_DEMAND] = 1'b1;
          next_st.out_qual = 1'b1;
          next_st.snd      = spd_pkg::SND_DESC1;
        end
        spd_pkg::SND_DESC1: begin
          next_st.out_word = '0;
          next_st.out_word[23:0] = st.job.len;
          next_st.out_flags[spd_pkg::OUT_DESC]   = 1'b1;
          next_st.out_flags[spd_pkg::OUT_DEMAND] = 1'b1;
          next_st.out_flags[spd_pkg::OUT_EOF]    = st.job.to_dev;
          next_st.out_qual = 1'b1;
          next_st.snd      = st.job.to_dev ? spd_pkg::SND_IDLE : spd_pkg::SND_DATA;
        end
        spd_pkg::SND_DATA: begin
          next_st.out_word = '0;
          for (int i = 0; i < DPB; i++) begin
            if (i >= int'(st.lane) && (i - int'(st.lane)) < int'(st.remaining)) begin
              next_st.out_word[32*i +: 32] = st.pattern + 32'(cnt);
              next_st.out_flags[out_bit(i)] = 1'b1;
              cnt = cnt + 24'h1;
            end
          end
          next_st.out_flags[spd_pkg::OUT_DEMAND] = st.job.demand;
          next_st.out_qual  = 1'b1;
          next_st.pattern   = st.pattern + 32'(cnt);
          next_st.remaining = st.remaining - cnt;
          next_st.lane      = '0;
          if (st.remaining == cnt) begin
            next_st.out_flags[spd_pkg::OUT_EOF] = 1'b1;
            next_st.snd = spd_pkg::SND_IDLE;
          end
        end
      endcase
    end

    // inbound stops while a job is pending; beats already in flight still land
    next_st.go = st.ctrl[spd_pkg::CTRL_GO] && next_st.snd == spd_pkg::SND_IDLE;
  end

  // one register for all state, synchronous reset
  always_ff @(posedge clock_in) begin
    if (rst_in) begin
      st          <= '0;
      st.ctrl     <= spd_pkg::CTRL_RESET;
      st.avs_wait <= 1'b1;
      st.snd      <= spd_pkg::SND_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign avs_readdata_out               = st.avs_rdata;
  assign avs_waitrequest_out            = st.avs_wait;
  assign target_write_accept_out        = st.wr_acc;
  assign target_read_accept_out         = st.rd_acc;
  assign target_read_data_out           = st.rd_data;
  assign target_read_data_tag_out       = st.rd_tag_out;
  assign target_read_data_ctrl_out      = st.rd_ctrl_out;
  assign target_read_data_valid_out     = st.rd_valid;
  assign engine0_inbound_go_out         = st.go;
  assign engine0_outbound_word_out      = st.out_word;
  assign engine0_outbound_flags_out     = st.out_flags;
  assign engine0_outbound_qualifier_out = st.out_qual;

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  wr_beat_a: assert property (mem_we |=> st.wr_count == $past(st.wr_count) + 32'h1)
    else $error("write beat not counted");
  rd_single_a: assert property (rd_take |=> !target_read_accept_out [*2])
    else $error("read accept not dropped while read in flight");
  tag_echo_a: assert property (rd_take |-> ##2 (target_read_data_valid_out &&
      target_read_data_tag_out == $past(target_request_tag_in, 2)))
    else $error("read tag not returned");
  rd_pulse_a: assert property (target_read_data_valid_out |=> !target_read_data_valid_out)
    else $error("read valid longer than one cycle");
  ctrl_echo_a: assert property (rd_take |-> ##2
      target_read_data_ctrl_out == $past(target_read_ctrl_in, 2))
    else $error("read size not echoed");
  eof_end_a: assert property ((st.snd == spd_pkg::SND_DATA && next_st.out_flags[spd_pkg::OUT_EOF])
      |=> engine0_outbound_qualifier_out && st.snd == spd_pkg::SND_IDLE && st.remaining == 24'h0)
    else $error("eof not on last dword");
  go_drop_a: assert property ((st.snd == spd_pkg::SND_IDLE && next_st.snd == spd_pkg::SND_DATA)
      |=> !engine0_inbound_go_out)
    else $error("go held during outbound job");
  host_rsv_a: assert property ((engine0_outbound_qualifier_out && !st.job.demand) |->
      engine0_outbound_flags_out[spd_pkg::OUT_RSV_HI:spd_pkg::OUT_DESC] == 4'h0 &&
      !engine0_outbound_flags_out[spd_pkg::OUT_DEMAND])
    else $error("reserved outbound bits set");
  desc_flag_a: assert property ((st.snd == spd_pkg::SND_DESC0 && !engine0_outbound_nearly_full_in)
      |=> engine0_outbound_flags_out[spd_pkg::OUT_DESC] ##1
          (!engine0_outbound_qualifier_out || engine0_outbound_flags_out[spd_pkg::OUT_DESC]))
    else $error("descriptor flag missing");
  full_stop_a: assert property (engine0_outbound_nearly_full_in |=> !engine0_outbound_qualifier_out)
    else $error("outbound beat sent while nearly full");
endmodule : spd_user_end
`default_nettype wire

/* File: bench/spd_adapter_model.sv */
/* spd_adapter_model: adapter side of the target and engine 0 inbound ports.
   Assumes: shares the user end's clock; 64-bit data. */
`timescale 1ns/1ns
`default_nettype none
module spd_adapter_model (
  input  wire logic        clock_in,
  input  wire logic        wr_acc_in,
  input  wire logic        rd_acc_in,
  input  wire logic        go_in,
  output logic      [63:0] addr_out,
  output logic             strobe_out,
  output logic      [63:0] wdata_out,
  output logic      [7:0]  mask_out,
  output logic             wen_out,
  output logic             ren_out,
  output logic      [3:0]  tag_out,
  output logic      [7:0]  size_out,
  output logic      [63:0] word_out,
  output logic      [7:0]  flags_out,
  output logic             qual_out
);
  // stands for a shared-clock adapter with all engines on; the upstream
  // type and valid selector routing hands only engine 0 beats to this port
  initial {addr_out, strobe_out, wdata_out, mask_out, wen_out, ren_out} = '0;
  initial {tag_out, size_out, word_out, flags_out, qual_out} = '0;
  // request held until accept is sampled; data lines scrambled after release
  task automatic req(input logic rd, input logic [63:0] a, d,
                     input logic [7:0] m, s, input logic [3:0] t);
    {addr_out, wdata_out, mask_out, size_out} <= {a, d, m, s};
    {strobe_out, wen_out, ren_out, tag_out} <= {1'b1, !rd, rd, t};
    // the address strobe lasts one cycle even when accept holds the beat back
    do begin
      @(posedge clock_in);
      strobe_out <= 1'b0;
    end while ((rd ? rd_acc_in : wr_acc_in) !== 1'b1);
    {wen_out, ren_out, wdata_out} <= {2'b00, ~d};
    @(posedge clock_in);
  endtask : req
  // address, length, data beats; only started while go is high
  task automatic burst(input logic [63:0] w[3], input logic [7:0] f[3]);
    while (go_in !== 1'b1) @(posedge clock_in);
    for (int i = 0; i < 3; i++) begin
      {word_out, flags_out, qual_out} <= {w[i], f[i], 1'b1};
      @(posedge clock_in);
    end
    {word_out, qual_out} <= {~w[2], 1'b0};
  endtask : burst
endmodule : spd_adapter_model
`default_nettype wire

/* File: bench/spd_user_end_tb_top.sv */
/* spd_user_end_tb_top: self-checking bench for the user end.
   Assumes: spd_adapter_model plays the adapter; one 10 MHz clock. */
`timescale 1ns/1ns
`default_nettype none
module spd_user_end_tb_top;
  logic        clock_in, rst_in, avs_read_in, avs_write_in, avs_waitrequest_out;
  logic [5:0]  avs_address_in;
  logic [31:0] avs_writedata_in, avs_readdata_out, q;
  logic [63:0] target_address_in, target_write_data_in, target_read_data_out;
  logic [63:0] engine0_inbound_word_in, engine0_outbound_word_out, ob_w[$];
  logic [7:0]  register_wr_byte_mask_in, register_rd_byte_mask_in, target_read_ctrl_in;
  logic [7:0]  target_read_data_ctrl_out, engine0_inbound_flags_in;
  logic [3:0]  target_request_tag_in, target_read_data_tag_out;
  logic [2:0]  debug_window_in;
  logic [8:0]  engine0_outbound_flags_out, ob_f[$];
  logic [15:0] v;
  logic        target_address_valid_in, target_write_enable_in, target_write_accept_out;
  logic        target_read_enable_in, target_read_accept_out, target_read_data_valid_out;
  logic        engine0_inbound_qualifier_in, engine0_inbound_go_out;
  logic        engine0_outbound_qualifier_out, engine0_outbound_nearly_full_in;
  int          miscompares = 0, check_count = 0, cycles = 0, n;
  spd_user_end #(.DATA_W(64)) dut (.*);
  spd_adapter_model m (.clock_in(clock_in), .wr_acc_in(target_write_accept_out),
    .rd_acc_in(target_read_accept_out), .go_in(engine0_inbound_go_out),
    .addr_out(target_address_in), .strobe_out(target_address_valid_in),
    .wdata_out(target_write_data_in), .mask_out(register_wr_byte_mask_in),
    .wen_out(target_write_enable_in), .ren_out(target_read_enable_in),
    .tag_out(target_request_tag_in), .size_out(target_read_ctrl_in),
    .word_out(engine0_inbound_word_in), .flags_out(engine0_inbound_flags_in),
    .qual_out(engine0_inbound_qualifier_in));
  assign register_rd_byte_mask_in = register_wr_byte_mask_in;
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end
  // outbound beat log and hang guard
  always @(posedge clock_in) begin
    cycles <= cycles + 1;
    if (engine0_outbound_qualifier_out === 1'b1) begin
      ob_f.push_back(engine0_outbound_flags_out);
      ob_w.push_back(engine0_outbound_word_out);
    end
    if (cycles == 3000) begin
      miscompares++;
      give_verdict();
    end
  end
  task automatic chk(input logic [63:0] got, exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // avalon access held until waitrequest is sampled low
  task automatic avs(input logic wr, input logic [5:0] a, input logic [31:0] d);
    {avs_address_in, avs_writedata_in, avs_write_in, avs_read_in} <= {a, d, wr, !wr};
    do @(posedge clock_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    {avs_write_in, avs_read_in} <= 2'b00;
    @(posedge clock_in);
  endtask : avs
  task automatic rchk(input logic [5:0] a, input logic [31:0] e);
    avs(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rchk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    {rst_in, avs_read_in, avs_write_in, avs_address_in, avs_writedata_in} = {1'b1, 40'h0};
    {debug_window_in, engine0_outbound_nearly_full_in} = {3'b010, 1'b0};
    repeat (8) @(posedge clock_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clock_in);
    rchk(spd_pkg::REG_CTRL, 32'h7);
    rchk(6'h3C, 32'h0);
    $display("test registers done");
    m.req(1'b0, 64'h8, 64'h1111_2222_3333_4444, 8'hFF, 8'h0, 4'h0);
    m.req(1'b0, 64'h8, 64'hAAAA_BBBB_CCCC_DDDD, 8'h0F, 8'h0, 4'h0);
    debug_window_in <= 3'b100;
    m.req(1'b1, 64'h8, 64'h0, 8'hFF, 8'h01, 4'hA);
    // answer awaited far inside the adapter's own read limit
    for (n = 0; n < 20 && target_read_data_valid_out !== 1'b1; n++) @(posedge clock_in);
    chk(target_read_data_out, 64'h1111_2222_CCCC_DDDD);
    chk({target_read_data_tag_out, target_read_data_ctrl_out}, 64'hA01);
    @(posedge clock_in);
    chk(target_read_data_valid_out, 64'h0);
    rchk(spd_pkg::REG_WR_COUNT, 32'h2);
    rchk(spd_pkg::REG_RD_COUNT, 32'h1);
    rchk(spd_pkg::REG_STATUS, 32'h10);
    $display("test target done");
    m.burst('{64'h100, 64'hFF_0000_0002, 64'h5_0000_0003}, '{8'h01, 8'h20, 8'h0C});
    rchk(spd_pkg::REG_LAST_LEN, 32'h2);
    rchk(spd_pkg::REG_IN_DWORDS, 32'h2);
    rchk(spd_pkg::REG_IN_SUM, 32'h8);
    $display("test inbound done");
    engine0_outbound_nearly_full_in <= 1'b1;
    avs(1'b1, spd_pkg::REG_DEM_ADDR, 32'h0);
    avs(1'b1, spd_pkg::REG_DEM_CMD, 32'h3);
    repeat (4) @(posedge clock_in);
    chk(ob_f.size(), 64'h0);
    engine0_outbound_nearly_full_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    chk(ob_f.size(), 64'h4);
    for (n = 0; n < 4; n++) v = {v[11:0], ob_f[n][4:2], ob_f[n][0]};
    chk(v, 64'hAA37);
    chk(ob_w[1], 64'h3);
    chk(ob_w[2], 64'h1_0000_0000);
    chk(ob_w[3], 64'h2);
    $display("test outbound done");
    m.burst('{64'h104, 64'h3, 64'h0}, '{8'h01, 8'h30, 8'h01});
    repeat (6) @(posedge clock_in);
    rchk(spd_pkg::REG_LAST_LEN, 32'h100_0003);
    chk(ob_f.size(), 64'h6);
    chk({ob_f[4], ob_f[5]}, 64'h40B);
    chk(ob_w[4], 64'h3_0000_0000);
    chk(ob_w[5], 64'h5_0000_0004);
    $display("test host read done");
    give_verdict();
  end
endmodule : spd_user_end_tb_top
`default_nettype wire
